// File: logic/vsdc_ctrl.sv
// oscillator section control registers, sync release, calibration, decoders
//
// Contract
// - with force clear, hold distribution in sync until output loop locks, then release
// - force-release set ignores lock state, releases distribution immediately
// - reference valid from input loop indicator, or always valid when overridden
// - midpoint-force bit drives oscillator control voltage to midscale
// - calibrate bit starts calibration, never cleared by hardware
// - writing calibrate bit zero returns calibration logic to idle
// - divider power-down bit powers down the oscillator divider
// - oscillator divided by code plus four, feeding all channels
// - pole and zero resistor fields decode to their ohm values
// - next register bit zero bypasses internal zero resistor, external needed
`timescale 1ns/1ps
module vsdc_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        output_loop_lock_in,
	input  wire logic        input_loop_osc_ok_in,
	output logic             dist_sync_hold,
	output logic             dist_sync_release,
	output logic             output_loop_ref_valid,
	output logic             osc_midscale,
	output logic             cal_busy,
	output logic             cal_done,
	output logic             osc_div_pd,
	output logic             osc_div_tick,
	output logic      [11:0] second_pole_resistor_ohm,
	output logic      [11:0] zero_resistor_ohm,
	output logic             ext_zero_resistor_req
);

	// -------------------------------------------------------------------
	// register file
	// -------------------------------------------------------------------
	logic [7:0] osc_ctrl_r;
	logic [7:0] osc_ctrl_nxt;
	logic [7:0] osc_div_r;
	logic [7:0] osc_div_nxt;
	logic [7:0] lf_ctrl_r;
	logic [7:0] lf_ctrl_nxt;
	logic [7:0] lf_msb_r;
	logic [7:0] lf_msb_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	always_comb begin
		osc_ctrl_nxt = osc_ctrl_r;
		osc_div_nxt  = osc_div_r;
		lf_ctrl_nxt  = lf_ctrl_r;
		lf_msb_nxt   = lf_msb_r;
		rdata_nxt    = rdata_r;
		// calibrate bit changes only by a write
		if (reg_wr_en) begin
			case (reg_addr)
				vsdc_pkg::OSC_CTRL_OFS: begin
					osc_ctrl_nxt = reg_wdata & vsdc_pkg::OSC_CTRL_MASK;
				end
				vsdc_pkg::OSC_DIV_CTRL_OFS: begin
					osc_div_nxt = reg_wdata & vsdc_pkg::OSC_DIV_MASK;
				end
				vsdc_pkg::LF_CTRL_OFS: begin
					lf_ctrl_nxt = reg_wdata & vsdc_pkg::LF_CTRL_MASK;
				end
				vsdc_pkg::LF_MSB_OFS: begin
					lf_msb_nxt = reg_wdata & vsdc_pkg::LF_MSB_MASK;
				end
				default: begin
				end
			endcase
		end
		// unmapped reads return zero
		if (reg_rd_en) begin
			case (reg_addr)
				vsdc_pkg::OSC_CTRL_OFS:     rdata_nxt = osc_ctrl_r;
				vsdc_pkg::OSC_DIV_CTRL_OFS: rdata_nxt = osc_div_r;
				vsdc_pkg::LF_CTRL_OFS:      rdata_nxt = lf_ctrl_r;
				vsdc_pkg::LF_MSB_OFS:       rdata_nxt = lf_msb_r;
				default:                    rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			osc_ctrl_r <= vsdc_pkg::OSC_CTRL_RST;
			osc_div_r  <= vsdc_pkg::OSC_DIV_RST;
			lf_ctrl_r  <= vsdc_pkg::LF_CTRL_RST;
			lf_msb_r   <= vsdc_pkg::LF_MSB_RST;
			rdata_r    <= 8'h00;
		end else begin
			osc_ctrl_r <= osc_ctrl_nxt;
			osc_div_r  <= osc_div_nxt;
			lf_ctrl_r  <= lf_ctrl_nxt;
			lf_msb_r   <= lf_msb_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	logic force_rel;
	logic ref_ovr;
	logic cal_bit;
	assign force_rel = osc_ctrl_r[vsdc_pkg::FORCE_REL_BIT];
	assign ref_ovr   = osc_ctrl_r[vsdc_pkg::REF_VALID_BIT];
	assign cal_bit   = osc_ctrl_r[vsdc_pkg::CAL_BIT];

	// -------------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------------
	// change accepted only when stages two and three agree
	logic [2:0] lock_sy_r;
	logic [2:0] osc_ok_sy_r;
	logic       lock_q_r;
	logic       lock_q_nxt;
	logic       osc_ok_q_r;
	logic       osc_ok_q_nxt;

	always_comb begin
		lock_q_nxt   = lock_q_r;
		osc_ok_q_nxt = osc_ok_q_r;
		if (lock_sy_r[1] == lock_sy_r[2]) begin
			lock_q_nxt = lock_sy_r[2];
		end
		if (osc_ok_sy_r[1] == osc_ok_sy_r[2]) begin
			osc_ok_q_nxt = osc_ok_sy_r[2];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lock_sy_r   <= 3'h0;
			osc_ok_sy_r <= 3'h0;
			lock_q_r    <= 1'b0;
			osc_ok_q_r  <= 1'b0;
		end else begin
			lock_sy_r   <= {lock_sy_r[1:0], output_loop_lock_in};
			osc_ok_sy_r <= {osc_ok_sy_r[1:0], input_loop_osc_ok_in};
			lock_q_r    <= lock_q_nxt;
			osc_ok_q_r  <= osc_ok_q_nxt;
		end
	end

	// -------------------------------------------------------------------
	// distribution sync and reference valid
	// -------------------------------------------------------------------
	logic hold_r;
	logic hold_nxt;
	logic rel_r;
	logic rel_nxt;
	logic refv_r;
	logic refv_nxt;

	always_comb begin
		hold_nxt = !(force_rel || lock_q_r);
		rel_nxt  = hold_r && !hold_nxt;
		// override makes the reference always valid
		refv_nxt = ref_ovr || osc_ok_q_r;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hold_r <= 1'b1;
			rel_r  <= 1'b0;
			refv_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			rel_r  <= rel_nxt;
			refv_r <= refv_nxt;
		end
	end

	assign dist_sync_hold        = hold_r;
	assign dist_sync_release     = rel_r;
	assign output_loop_ref_valid = refv_r;
	assign osc_midscale          = osc_ctrl_r[vsdc_pkg::MIDSCALE_BIT];

	// -------------------------------------------------------------------
	// calibration sequencer
	// -------------------------------------------------------------------
	// level-held request: a new run needs the bit to go 0 then 1
	vsdc_pkg::vsdc_cal_state_t cal_st_r;
	vsdc_pkg::vsdc_cal_state_t cal_st_nxt;
	logic [15:0]               cal_cnt_r;
	logic [15:0]               cal_cnt_nxt;

	always_comb begin
		cal_st_nxt  = cal_st_r;
		cal_cnt_nxt = cal_cnt_r;
		case (cal_st_r)
			vsdc_pkg::VSDC_CAL_IDLE: begin
				cal_cnt_nxt = 16'h0000;
				if (cal_bit) begin
					cal_st_nxt = vsdc_pkg::VSDC_CAL_RUN;
				end
			end
			vsdc_pkg::VSDC_CAL_RUN: begin
				cal_cnt_nxt = cal_cnt_r + 16'h0001;
				if (cal_cnt_r == 16'(vsdc_pkg::CAL_CYCLES - 1)) begin
					cal_st_nxt = vsdc_pkg::VSDC_CAL_DONE;
				end
			end
			vsdc_pkg::VSDC_CAL_DONE: begin
			end
			default: begin
				cal_st_nxt = vsdc_pkg::VSDC_CAL_IDLE;
			end
		endcase
		if (!cal_bit) begin
			cal_st_nxt  = vsdc_pkg::VSDC_CAL_IDLE;
			cal_cnt_nxt = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cal_st_r  <= vsdc_pkg::VSDC_CAL_IDLE;
			cal_cnt_r <= 16'h0000;
		end else begin
			cal_st_r  <= cal_st_nxt;
			cal_cnt_r <= cal_cnt_nxt;
		end
	end

	assign cal_busy = (cal_st_r == vsdc_pkg::VSDC_CAL_RUN);
	assign cal_done = (cal_st_r == vsdc_pkg::VSDC_CAL_DONE);

	// -------------------------------------------------------------------
	// oscillator divider
	// -------------------------------------------------------------------
	// power-down bit straight to divider
	assign osc_div_pd = osc_div_r[vsdc_pkg::DIV_PD_BIT];

	// one divided rate shared by all channels
	vsdc_osc_divider u_div (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.power_down (osc_div_pd),
		.div_code   (osc_div_r[vsdc_pkg::DIV_CODE_LSB +: 3]),
		.div_tick   (osc_div_tick)
	);

	// -------------------------------------------------------------------
	// loop filter decode
	// -------------------------------------------------------------------
	logic [11:0] pole_r;
	logic [11:0] pole_nxt;
	logic [11:0] zero_r;
	logic [11:0] zero_nxt;
	logic        byp_r;
	logic        byp_nxt;

	always_comb begin
		case (lf_ctrl_r[vsdc_pkg::POLE_LSB +: 2])
			2'h0:    pole_nxt = vsdc_pkg::POLE_OHM_0;
			2'h1:    pole_nxt = vsdc_pkg::POLE_OHM_1;
			2'h2:    pole_nxt = vsdc_pkg::POLE_OHM_2;
			default: pole_nxt = vsdc_pkg::POLE_OHM_3;
		endcase
		case (lf_ctrl_r[vsdc_pkg::ZERO_LSB +: 3])
			3'h0:    zero_nxt = vsdc_pkg::ZERO_OHM_0;
			3'h1:    zero_nxt = vsdc_pkg::ZERO_OHM_1;
			3'h2:    zero_nxt = vsdc_pkg::ZERO_OHM_2;
			3'h3:    zero_nxt = vsdc_pkg::ZERO_OHM_3;
			3'h4:    zero_nxt = vsdc_pkg::ZERO_OHM_4;
			3'h5:    zero_nxt = vsdc_pkg::ZERO_OHM_5;
			3'h6:    zero_nxt = vsdc_pkg::ZERO_OHM_6;
			default: zero_nxt = vsdc_pkg::ZERO_OHM_7;
		endcase
		byp_nxt = lf_msb_r[vsdc_pkg::BYPASS_BIT];
		if (byp_nxt) begin
			zero_nxt = 12'h000;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pole_r <= vsdc_pkg::POLE_OHM_0;
			zero_r <= vsdc_pkg::ZERO_OHM_0;
			byp_r  <= 1'b0;
		end else begin
			pole_r <= pole_nxt;
			zero_r <= zero_nxt;
			byp_r  <= byp_nxt;
		end
	end

	assign second_pole_resistor_ohm = pole_r;
	assign zero_resistor_ohm        = zero_r;
	assign ext_zero_resistor_req    = byp_r;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	a_hold_until_lock: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(!force_rel && !lock_q_r) |=> dist_sync_hold)
		else $error("distribution released without lock");

	a_force_release: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		force_rel |=> !dist_sync_hold)
		else $error("force release did not release distribution");

	a_release_pulse: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$fell(dist_sync_hold) |-> dist_sync_release ##1 !dist_sync_release)
		else $error("release pulse missing or too long");

	a_ref_valid_ovr: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		ref_ovr |=> output_loop_ref_valid)
		else $error("override did not mark reference valid");

	a_ref_valid_src: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(!ref_ovr && !osc_ok_q_r) |=> !output_loop_ref_valid)
		else $error("reference valid without indicator");

	a_cal_bit_held: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(cal_bit && !reg_wr_en) |=> cal_bit)
		else $error("calibrate bit cleared by hardware");

	a_cal_starts: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(cal_st_r == vsdc_pkg::VSDC_CAL_IDLE && cal_bit) |=> cal_busy || !cal_bit)
		else $error("calibration did not start");

	a_cal_reset: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!cal_bit |=> (cal_st_r == vsdc_pkg::VSDC_CAL_IDLE) && cal_cnt_r == 16'h0000)
		else $error("calibration not reset by clear");

	a_bypass_zero: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		lf_msb_r[vsdc_pkg::BYPASS_BIT] |=> zero_resistor_ohm == 12'h000 && ext_zero_resistor_req)
		else $error("bypass did not zero the resistor");

	a_pole_decode: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(lf_ctrl_r[7:6] == 2'h3) |=> second_pole_resistor_ohm == 12'h0e1)
		else $error("pole code 3 not decoded to 225");

endmodule

// File: logic/vsdc_pkg.sv
// constants and types shared by the oscillator section control logic
package vsdc_pkg;

	// -------------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------------
	localparam logic [9:0] OSC_CTRL_OFS     = 10'h0f3;
	localparam logic [9:0] OSC_DIV_CTRL_OFS = 10'h0f4;
	localparam logic [9:0] LF_CTRL_OFS      = 10'h0f5;
	localparam logic [9:0] LF_MSB_OFS       = 10'h0f6;

	// -------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------
	localparam int FORCE_REL_BIT  = 4;
	localparam int REF_VALID_BIT  = 3;
	localparam int MIDSCALE_BIT   = 2;
	localparam int CAL_BIT        = 1;
	localparam int DIV_PD_BIT     = 3;
	localparam int DIV_CODE_LSB   = 0;
	localparam int POLE_LSB       = 6;
	localparam int ZERO_LSB       = 3;
	localparam int BYPASS_BIT     = 0;

	// -------------------------------------------------------------------
	// writable bit masks, reset values
	// -------------------------------------------------------------------
	localparam logic [7:0] OSC_CTRL_MASK = 8'h1e;
	localparam logic [7:0] OSC_DIV_MASK  = 8'h0f;
	localparam logic [7:0] LF_CTRL_MASK  = 8'hf8;
	localparam logic [7:0] LF_MSB_MASK   = 8'h01;
	localparam logic [7:0] OSC_CTRL_RST  = 8'h00;
	localparam logic [7:0] OSC_DIV_RST   = 8'h00;
	localparam logic [7:0] LF_CTRL_RST   = 8'h00;
	localparam logic [7:0] LF_MSB_RST    = 8'h00;

	// -------------------------------------------------------------------
	// divider and timing
	// -------------------------------------------------------------------
	localparam logic [3:0] DIV_BASE      = 4'h4;
	localparam int         CLK_PERIOD_PS = 25000;
	localparam int         CAL_TIME_NS   = 2000;
	localparam int         CAL_CYCLES    = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// -------------------------------------------------------------------
	// resistor values in ohms
	// -------------------------------------------------------------------
	localparam logic [11:0] POLE_OHM_0 = 12'h384; // 900
	localparam logic [11:0] POLE_OHM_1 = 12'h1c2; // 450
	localparam logic [11:0] POLE_OHM_2 = 12'h12c; // 300
	localparam logic [11:0] POLE_OHM_3 = 12'h0e1; // 225
	localparam logic [11:0] ZERO_OHM_0 = 12'hcb2; // 3250
	localparam logic [11:0] ZERO_OHM_1 = 12'habe; // 2750
	localparam logic [11:0] ZERO_OHM_2 = 12'h8ca; // 2250
	localparam logic [11:0] ZERO_OHM_3 = 12'h834; // 2100
	localparam logic [11:0] ZERO_OHM_4 = 12'hbb8; // 3000
	localparam logic [11:0] ZERO_OHM_5 = 12'h9c4; // 2500
	localparam logic [11:0] ZERO_OHM_6 = 12'h7d0; // 2000
	localparam logic [11:0] ZERO_OHM_7 = 12'h73a; // 1850

	typedef enum logic [2:0] {
		VSDC_CAL_IDLE = 3'b001,
		VSDC_CAL_RUN  = 3'b010,
		VSDC_CAL_DONE = 3'b100
	} vsdc_cal_state_t;

endpackage

// File: logic/vsdc_osc_divider.sv
// programmable divider making the shared channel rate enable
`timescale 1ns/1ps
module vsdc_osc_divider (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       power_down,
	input  wire logic [2:0] div_code,
	output logic            div_tick
);

	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic [3:0] ratio;

	// -------------------------------------------------------------------
	// count to ratio
	// -------------------------------------------------------------------
	always_comb begin
		ratio    = {1'b0, div_code} + vsdc_pkg::DIV_BASE;
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (power_down) begin
			cnt_nxt = 4'h0;
		end else if (cnt_r >= ratio - 4'h1) begin
			cnt_nxt  = 4'h0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 4'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign div_tick = tick_r;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	a_div_pd_quiet: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		power_down |=> !div_tick)
		else $error("divider ticked while powered down");

	a_div_ratio_gap: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		div_tick |=> !div_tick [*3])
		else $error("divider ticks closer than four cycles");

endmodule

// File: verif/tb.sv
// self-checking bench for the oscillator section control block
`timescale 1ns/1ps
module tb;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        ref_clk;
	logic        resetn;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [9:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        lock_pin;
	logic        osc_ok_pin;
	logic        dist_sync_hold;
	logic        dist_sync_release;
	logic        ref_valid;
	logic        osc_midscale;
	logic        cal_busy;
	logic        cal_done;
	logic        osc_div_pd;
	logic        osc_div_tick;
	logic [11:0] pole_ohm;
	logic [11:0] zero_ohm;
	logic        ext_req;
	int          n_mismatch;
	int          checks;
	int          k;
	int          cnt;
	logic [11:0] pole_tab [4];
	logic [11:0] zero_tab [8];
	logic [7:0]  full_rd [4];

	vsdc_ctrl vsdc_ctrl_inst (
		.ref_clk                  (ref_clk),
		.resetn                   (resetn),
		.reg_wr_en                (reg_wr_en),
		.reg_rd_en                (reg_rd_en),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_rdata                (reg_rdata),
		.output_loop_lock_in      (lock_pin),
		.input_loop_osc_ok_in     (osc_ok_pin),
		.dist_sync_hold           (dist_sync_hold),
		.dist_sync_release        (dist_sync_release),
		.output_loop_ref_valid    (ref_valid),
		.osc_midscale             (osc_midscale),
		.cal_busy                 (cal_busy),
		.cal_done                 (cal_done),
		.osc_div_pd               (osc_div_pd),
		.osc_div_tick             (osc_div_tick),
		.second_pole_resistor_ohm (pole_ohm),
		.zero_resistor_ohm        (zero_ohm),
		.ext_zero_resistor_req    (ext_req)
	);

	always #12.5 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic complete_run;
		if (n_mismatch == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// settle point just after an edge, so registered outputs have landed
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string name);
		@(posedge ref_clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		#1;
		chk(name, {4'h0, exp}, {4'h0, reg_rdata});
	endtask

	function automatic logic sig(input int which);
		case (which)
			0: return dist_sync_hold;
			1: return cal_busy;
			default: return osc_div_tick;
		endcase
	endfunction

	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_for(input int which, input logic val, input int lim, input string name);
		int i;
		i = 0;
		while (sig(which) !== val) begin
			if (i == lim) begin
				n_mismatch++;
				$display("ERROR %s expected %h seen timeout", name, val);
				complete_run();
			end
			step(1);
			i++;
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		lock_pin = 1'b0;
		osc_ok_pin = 1'b0;
		n_mismatch = 0;
		checks = 0;
		pole_tab = '{12'h384, 12'h1c2, 12'h12c, 12'h0e1};
		zero_tab = '{12'hcb2, 12'habe, 12'h8ca, 12'h834, 12'hbb8, 12'h9c4, 12'h7d0, 12'h73a};
		full_rd = '{8'h1e, 8'h0f, 8'hf8, 8'h01};
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		step(2);
		chk("hold after reset", 12'h001, {11'h0, dist_sync_hold});
		chk("pole after reset", 12'h384, pole_ohm);
		chk("zero after reset", 12'hcb2, zero_ohm);
		// reserved bits read zero, unmapped place ignored
		for (k = 0; k < 4; k++) begin
			rd(10'h0f3 + 10'(k), 8'h00, "reset value");
			wr(10'h0f3 + 10'(k), 8'hff);
			rd(10'h0f3 + 10'(k), full_rd[k], "writable bits");
			wr(10'h0f3 + 10'(k), 8'h00);
		end
		wr(10'h0f7, 8'hff);
		rd(10'h0f7, 8'h00, "unmapped read");
		// reference valid source and override
		step(6);
		chk("ref valid low", 12'h000, {11'h0, ref_valid});
		@(posedge ref_clk);
		osc_ok_pin <= 1'b1;
		step(6);
		chk("ref valid follows", 12'h001, {11'h0, ref_valid});
		@(posedge ref_clk);
		osc_ok_pin <= 1'b0;
		wr(10'h0f3, 8'h08);
		step(6);
		chk("ref valid forced", 12'h001, {11'h0, ref_valid});
		wr(10'h0f3, 8'h04);
		step(6);
		chk("ref valid dropped", 12'h000, {11'h0, ref_valid});
		chk("midscale set", 12'h001, {11'h0, osc_midscale});
		wr(10'h0f3, 8'h00);
		step(2);
		chk("midscale clear", 12'h000, {11'h0, osc_midscale});
		// lock driven release, then loss of lock
		chk("hold unlocked", 12'h001, {11'h0, dist_sync_hold});
		@(posedge ref_clk);
		lock_pin <= 1'b1;
		wait_for(0, 1'b0, 10, "hold release");
		chk("release pulse", 12'h001, {11'h0, dist_sync_release});
		step(1);
		chk("release pulse end", 12'h000, {11'h0, dist_sync_release});
		@(posedge ref_clk);
		lock_pin <= 1'b0;
		wait_for(0, 1'b1, 10, "hold again");
		// forced release ignores the unlocked detector
		wr(10'h0f3, 8'h10);
		wait_for(0, 1'b0, 4, "forced release");
		chk("forced pulse", 12'h001, {11'h0, dist_sync_release});
		step(20);
		chk("forced stays", 12'h000, {11'h0, dist_sync_hold});
		wr(10'h0f3, 8'h00);
		wait_for(0, 1'b1, 4, "force removed");
		// calibration runs, bit stays set
		wr(10'h0f3, 8'h02);
		wait_for(1, 1'b1, 3, "cal start");
		cnt = 0;
		while (cal_busy === 1'b1 && cnt < 200) begin
			step(1);
			cnt++;
		end
		chk("cal length", 12'(vsdc_pkg::CAL_CYCLES), 12'(cnt));
		chk("cal done", 12'h001, {11'h0, cal_done});
		step(20);
		rd(10'h0f3, 8'h02, "cal bit held");
		wr(10'h0f3, 8'h00);
		step(2);
		chk("cal idle busy", 12'h000, {11'h0, cal_busy});
		chk("cal idle done", 12'h000, {11'h0, cal_done});
		wr(10'h0f3, 8'h02);
		wait_for(1, 1'b1, 3, "cal restart");
		step(10);
		wr(10'h0f3, 8'h00);
		step(2);
		chk("cal abort busy", 12'h000, {11'h0, cal_busy});
		// divider period for every code
		for (k = 0; k < 8; k++) begin
			wr(10'h0f4, 8'(k));
			wait_for(2, 1'b1, 20, "first tick");
			step(1);
			wait_for(2, 1'b1, 20, "second tick");
			step(1);
			cnt = 1;
			while (osc_div_tick !== 1'b1 && cnt < 20) begin
				step(1);
				cnt++;
			end
			chk("divide ratio", 12'(k + 4), 12'(cnt));
		end
		wr(10'h0f4, 8'h0b);
		step(2);
		chk("divider pd", 12'h001, {11'h0, osc_div_pd});
		cnt = 0;
		repeat (24) begin
			step(1);
			if (osc_div_tick !== 1'b0) cnt++;
		end
		chk("ticks while pd", 12'h000, 12'(cnt));
		wr(10'h0f4, 8'h00);
		step(2);
		chk("divider on", 12'h000, {11'h0, osc_div_pd});
		// resistor decoders and bypass
		for (k = 0; k < 4; k++) begin
			wr(10'h0f5, {2'(k), 6'h00});
			step(3);
			chk("pole ohm", pole_tab[k], pole_ohm);
		end
		for (k = 0; k < 8; k++) begin
			wr(10'h0f5, {2'h0, 3'(k), 3'h0});
			step(3);
			chk("zero ohm", zero_tab[k], zero_ohm);
		end
		wr(10'h0f6, 8'h01);
		step(3);
		chk("zero bypassed", 12'h000, zero_ohm);
		chk("ext resistor", 12'h001, {11'h0, ext_req});
		wr(10'h0f6, 8'h00);
		step(3);
		chk("ext resistor off", 12'h000, {11'h0, ext_req});
		// second reset in mid-run clears the registers
		wr(10'h0f3, 8'h1e);
		@(posedge ref_clk);
		resetn <= 1'b0;
		step(2);
		chk("hold in reset", 12'h001, {11'h0, dist_sync_hold});
		@(posedge ref_clk);
		resetn <= 1'b1;
		step(2);
		rd(10'h0f3, 8'h00, "value after reset");
		complete_run();
	end
endmodule
